// ### sctr_synth_tick.v
`include "sctr_defines.vh"
`timescale 1ns/1ns
module sctr_synth_tick #(
  parameter CNT_W = `SCTR_CNT_W
)(
  input wire clock,
  input wire rst_n,
  input wire clkEn,
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  input wire oscTick,
  input wire oscLost,
  input wire specialMode,
  input wire fullStop,
  input wire pseudoStop,
  output reg synthOn,
  output reg autoBandwidth,
  output reg highBandwidth,
  output reg tickRunPs,
  output reg watchdogRunPs,
  output reg monitorResetReq,
  output reg selfClockActive,
  output reg tickIrq
);
  // ==========================================================
  // State
  reg [7:0] synthCtl_r;
  reg [7:0] tickCtl_r;
  reg [3:0] aux_r;
  reg scfeWritten_r;
  reg tickFlag_r;
  reg [CNT_W-1:0] tickCnt_r;
  reg ack_r;
  reg [7:0] synthCtl_nxt;
  wire rdy;
  wire wrSynth;
  wire wrTick;
  wire wrAux;
  wire wrFlagClr;
  wire [CNT_W-1:0] tickLimit;
  wire tickHit;
  wire monActive;
  wire [7:0] wd;

  // Divide count minus one, from prefactor and modulus.
  function [CNT_W-1:0] tick_div;
    input [6:0] code;
    reg [CNT_W-1:0] base;
    begin
      base = {{(CNT_W-1){1'b0}}, 1'b1} << (`SCTR_PRE_BASE + code[6:4]);
      tick_div = base * {{(CNT_W-5){1'b0}}, 1'b0, code[3:0]} + base - 1'b1;
    end
  endfunction

  // ==========================================================
  // Bus decode: one wait cycle, the answer comes on the second edge.
  assign rdy = (read | write) & ack_r;
  assign wd = writedata[7:0];
  assign wrSynth = write & rdy & (address == `SCTR_ADDR_SYNTH);
  assign wrTick = write & rdy & (address == `SCTR_ADDR_TICK);
  assign wrAux = write & rdy & (address == `SCTR_ADDR_AUX);
  assign wrFlagClr = wrAux & writedata[`SCTR_B_TFLAG];
  assign tickLimit = tick_div(tickCtl_r[6:0]);
  // The tick advances only on oscillator-derived strobes, never the bus clock alone.
  assign tickHit = oscTick & (tickCtl_r[6:4] != 3'h0) & (tickCnt_r == tickLimit);
  // Monitor is dead in full stop unless pseudo-stop keeps the oscillator alive.
  assign monActive = synthCtl_r[`SCTR_B_CME] & ~(fullStop & ~aux_r[`SCTR_B_PSEUDO_STOP_SELECT]);

  // Per-bit write qualification for the synth control register.
  always @*
  begin
    synthCtl_nxt = synthCtl_r;
    if (wrSynth)
    begin
      if (~selfClockActive)
        synthCtl_nxt[`SCTR_B_CME] = wd[`SCTR_B_CME];
      if (~aux_r[`SCTR_B_SEL])
        synthCtl_nxt[`SCTR_B_PON] = wd[`SCTR_B_PON];
      if (~aux_r[`SCTR_B_SWAI])
        synthCtl_nxt[`SCTR_B_AUTO] = wd[`SCTR_B_AUTO];
      synthCtl_nxt[`SCTR_B_HIBW] = wd[`SCTR_B_HIBW];
      synthCtl_nxt[`SCTR_B_TRUN] = wd[`SCTR_B_TRUN];
      synthCtl_nxt[`SCTR_B_WRUN] = wd[`SCTR_B_WRUN];
      if ((specialMode | ~scfeWritten_r) & ~(selfClockActive & ~wd[`SCTR_B_SCFE]))
        synthCtl_nxt[`SCTR_B_SCFE] = wd[`SCTR_B_SCFE];
    end
    if (aux_r[`SCTR_B_SWAI])
      synthCtl_nxt[`SCTR_B_AUTO] = 1'b1;
  end

  // ==========================================================
  // Registers and bus answer.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      synthCtl_r <= `SCTR_RST_SYNTH;
      tickCtl_r <= `SCTR_RST_TICK;
      aux_r <= 4'h0;
      scfeWritten_r <= 1'b0;
      ack_r <= 1'b0;
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end
    else if (clkEn)
    begin
      synthCtl_r <= synthCtl_nxt;
      if (wrSynth)
        scfeWritten_r <= 1'b1;
      if (wrTick)
        tickCtl_r <= {1'b0, wd[6:0]};
      if (wrAux)
        aux_r <= wd[3:0];
      ack_r <= (read | write) & ~ack_r;
      waitrequest <= ~((read | write) & ~ack_r);
      if (read & ~ack_r)
      begin
        case (address)
          `SCTR_ADDR_SYNTH: readdata <= {24'h000000, synthCtl_r};
          `SCTR_ADDR_TICK: readdata <= {24'h000000, tickCtl_r};
          `SCTR_ADDR_AUX: readdata <= {27'h0000000, tickFlag_r, aux_r};
          default: readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // Tick divider chain and flag; the set wins over a software clear.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tickCnt_r <= {CNT_W{1'b0}};
      tickFlag_r <= 1'b0;
      tickIrq <= 1'b0;
    end
    else if (clkEn)
    begin
      if (wrTick)
        tickCnt_r <= {CNT_W{1'b0}};
      else if (pseudoStop & ~synthCtl_r[`SCTR_B_TRUN])
        tickCnt_r <= tickCnt_r;
      else if (tickHit)
        tickCnt_r <= {CNT_W{1'b0}};
      else if (oscTick & (tickCtl_r[6:4] != 3'h0))
        tickCnt_r <= tickCnt_r + 1'b1;
      if (tickHit & ~(pseudoStop & ~synthCtl_r[`SCTR_B_TRUN]) & ~wrTick)
        tickFlag_r <= 1'b1;
      else if (wrFlagClr)
        tickFlag_r <= 1'b0;
      tickIrq <= tickFlag_r & aux_r[`SCTR_B_TIE];
    end
  end

  // ==========================================================
  // Clock monitor, self-clock and synthesizer outputs.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      selfClockActive <= 1'b0;
      monitorResetReq <= 1'b0;
      synthOn <= 1'b0;
      autoBandwidth <= 1'b0;
      highBandwidth <= 1'b0;
      tickRunPs <= 1'b0;
      watchdogRunPs <= 1'b0;
    end
    else if (clkEn)
    begin
      if (monActive & oscLost & synthCtl_r[`SCTR_B_SCFE])
        selfClockActive <= 1'b1;
      else if (~oscLost)
        selfClockActive <= 1'b0;
      monitorResetReq <= monActive & oscLost & ~synthCtl_r[`SCTR_B_SCFE];
      synthOn <= synthCtl_r[`SCTR_B_PON] | selfClockActive;
      autoBandwidth <= synthCtl_r[`SCTR_B_AUTO];
      highBandwidth <= synthCtl_r[`SCTR_B_AUTO] ? 1'b0 : synthCtl_r[`SCTR_B_HIBW];
      tickRunPs <= synthCtl_r[`SCTR_B_TRUN];
      watchdogRunPs <= synthCtl_r[`SCTR_B_WRUN];
    end
  end
endmodule // sctr_synth_tick

// ### sctr_defines.vh
`ifndef SCTR_DEFINES_VH
`define SCTR_DEFINES_VH
// Register byte offsets: each register index sits four bytes apart on the word bus.
`define SCTR_IDX_SYNTH 4'h6
`define SCTR_IDX_TICK 4'h7
`define SCTR_IDX_AUX 4'h8
`define SCTR_ADDR_W 6
`define SCTR_ADDR_SYNTH 6'h18
`define SCTR_ADDR_TICK 6'h1c
`define SCTR_ADDR_AUX 6'h20
// Synth control field positions.
`define SCTR_B_CME 7
`define SCTR_B_PON 6
`define SCTR_B_AUTO 5
`define SCTR_B_HIBW 4
`define SCTR_B_TRUN 2
`define SCTR_B_WRUN 1
`define SCTR_B_SCFE 0
// Aux control bits (synth_clock_select, pseudo_stop_select, synth_stop_in_wait, tick_interrupt_enable).
`define SCTR_B_SEL 0
`define SCTR_B_PSEUDO_STOP_SELECT 1
`define SCTR_B_SWAI 2
`define SCTR_B_TIE 3
// Aux status bits read back.
`define SCTR_B_TFLAG 4
// Reset values.
`define SCTR_RST_SYNTH 8'h61
`define SCTR_RST_TICK 8'h00
`define SCTR_RST_AUX 8'h00
// Tick prescale base exponent and counter width.
`define SCTR_PRE_BASE 9
`define SCTR_CNT_W 21
`endif

// ### sctr_synth_tick_monitor.sv
`timescale 1ns/1ns
`include "sctr_defines.vh"
// ====================
// Port checker for the synthesizer and tick control block.
module sctr_synth_tick_monitor (
  input wire clock,
  input wire rst_n,
  input wire clkEn,
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire waitrequest,
  input wire oscLost,
  input wire fullStop,
  input wire pseudoStop,
  input wire synthOn,
  input wire autoBandwidth,
  input wire highBandwidth,
  input wire tickRunPs,
  input wire watchdogRunPs,
  input wire monitorResetReq,
  input wire selfClockActive
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A synth register write lands at the edge where waitrequest is low.
  sequence synthWr;
    write && !waitrequest && address == `SCTR_ADDR_SYNTH;
  endsequence
  // Two cycles allow for an output flop behind the register bit.
  tick_run_a: assert property (synthWr |-> ##2 tickRunPs == $past(writedata[2], 2))
    else $error("tick run bit not followed");
  wdog_run_a: assert property (synthWr |-> ##2 watchdogRunPs == $past(writedata[1], 2))
    else $error("watchdog run bit not followed");
  bus_answer_a: assert property ((read || write) && waitrequest && clkEn |=> !waitrequest)
    else $error("bus answer late");
  bw_excl_a: assert property (autoBandwidth |-> !highBandwidth)
    else $error("high bandwidth in auto mode");
  self_synth_a: assert property (selfClockActive && $past(selfClockActive) |-> synthOn)
    else $error("synth off in self clock");
  fail_excl_a: assert property (!(monitorResetReq && selfClockActive))
    else $error("reset and self clock together");
  loss_cause_a: assert property ($rose(monitorResetReq) || $rose(selfClockActive) |-> $past(oscLost))
    else $error("clock loss action without loss");
  stop_quiet_a: assert property ($rose(monitorResetReq) |-> !$past(fullStop && !pseudoStop))
    else $error("monitor active in full stop");
endmodule // sctr_synth_tick_monitor
bind sctr_synth_tick sctr_synth_tick_monitor sctr_synth_tick_monitor_i (.*);

// ### sctr_synth_tick_tb.sv
`timescale 1ns/1ns
`include "sctr_defines.vh"
// ====================
// Bench for the synthesizer and tick control block.
module sctr_synth_tick_tb;
  reg clock = 0, rst_n = 0, read = 0, write = 0, oscLost = 0;
  reg specialMode = 0, fullStop = 0, pseudoStop = 0;
  reg [5:0] address = 0;
  reg [31:0] writedata = 0, q;
  wire [31:0] readdata;
  wire waitrequest, synthOn, autoBandwidth, highBandwidth, tickRunPs, watchdogRunPs;
  wire monitorResetReq, selfClockActive, tickIrq;
  integer failures = 0, num_checks = 0, n;
  // Every clock is an oscillator strobe, so tick periods count in bus cycles.
  sctr_synth_tick sctr_synth_tick_i (.clkEn(1'b1), .oscTick(1'b1), .*);
  // Clock generator.
  initial
  begin
    forever #4 clock = ~clock;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  // One bus access; the leading edge keeps two transfers from driving in one step.
  task bus(input wr, input [5:0] a, input [7:0] d);
    begin
      @(posedge clock);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= {24'h0, d};
      do @(posedge clock); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 0;
      write <= 0;
    end
  endtask
  task rd(input [5:0] a, input [7:0] exp);
    begin
      bus(0, a, 8'h00);
      check(q, {24'h0, exp});
    end
  endtask
  // Time from a rate write to the interrupt, then clear the flag.
  task tick(input [7:0] code, input integer per);
    begin
      bus(1, `SCTR_ADDR_TICK, code);
      n = 0;
      while (tickIrq !== 1'b1 && n < 70000)
      begin
        @(posedge clock);
        n = n + 1;
      end
      check(n > per - 4 && n < per + 4, 1);
      bus(1, `SCTR_ADDR_AUX, 8'h18);
      $display("tick rate %h done", code);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // ====================
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1;
    rd(`SCTR_ADDR_TICK, 8'h00);
    rd(6'h3c, 8'h00);
    bus(1, `SCTR_ADDR_TICK, 8'h5a);
    rd(`SCTR_ADDR_TICK, 8'h5a);
    bus(1, `SCTR_ADDR_SYNTH, 8'he1);
    oscLost <= 1;
    repeat (8) @(posedge clock);
    check(selfClockActive, 1);
    bus(1, `SCTR_ADDR_SYNTH, 8'h26);
    check(synthOn, 1);
    rd(`SCTR_ADDR_SYNTH, 8'ha7);
    oscLost <= 0;
    repeat (8) @(posedge clock);
    check(synthOn, 0);
    specialMode <= 1;
    bus(1, `SCTR_ADDR_SYNTH, 8'h90);
    rd(`SCTR_ADDR_SYNTH, 8'h90);
    check(highBandwidth, 1);
    oscLost <= 1;
    repeat (8) @(posedge clock);
    check(monitorResetReq, 1);
    fullStop <= 1;
    repeat (4) @(posedge clock);
    check(monitorResetReq, 0);
    fullStop <= 0;
    oscLost <= 0;
    bus(1, `SCTR_ADDR_AUX, 8'h01);
    bus(1, `SCTR_ADDR_SYNTH, 8'hd0);
    rd(`SCTR_ADDR_SYNTH, 8'h90);
    bus(1, `SCTR_ADDR_AUX, 8'h04);
    repeat (3) @(posedge clock);
    check(autoBandwidth, 1);
    bus(1, `SCTR_ADDR_AUX, 8'h08);
    $display("register tests done");
    tick(8'h10, 1024);
    tick(8'h11, 2048);
    tick(8'h20, 2048);
    tick(8'h1f, 16384);
    bus(1, `SCTR_ADDR_TICK, 8'h10);
    pseudoStop <= 1;
    repeat (2000) @(posedge clock);
    check(tickIrq, 0);
    pseudoStop <= 0;
    repeat (1030) @(posedge clock);
    check(tickIrq, 1);
    bus(1, `SCTR_ADDR_AUX, 8'h18);
    bus(1, `SCTR_ADDR_TICK, 8'h0f);
    repeat (3000) @(posedge clock);
    check(tickIrq, 0);
    test_done;
  end
  // A hang is cut short well after the expected run length.
  initial
  begin
    repeat (80000) @(posedge clock);
    failures = failures + 1;
    test_done;
  end
endmodule // sctr_synth_tick_tb
